// [src/wdg_top.sv]
// watchdog timer with guarded control writes, lock bit and flash key check
// assumes a core that writes sfrs one byte at a time and pulses INSTR_DONE at each instruction end
`timescale 1ns/10ps
`include "wdg_regs.svh"
module wdg_top
    import wdg_pkg::*;
#(
    parameter int CNT_W = `WDG_CNT_W
) (
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    input  wire logic        XTAL_CLK,
    input  wire logic        INSTR_DONE,
    input  wire logic [7:0]  SFR_ADDR,
    input  wire logic        SFR_WR,
    input  wire logic [7:0]  SFR_WDATA,
    input  wire logic [7:0]  LOCK_BYTE,
    input  wire logic [7:0]  FLASH_GUARD_KEY,
    input  wire logic        PROT_REQ,
    output logic      [7:0]  SFR_RDATA,
    output logic             SYS_RESET,
    output logic             DL_RESET,
    output logic             WDT_IRQ,
    output logic             PROT_WR,
    output logic      [13:0] PROT_WR_ADDR,
    output logic             PROT_DENY
);

    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    // the mask decode assumes exactly one bit per prescaler step above the base shift
    if (CNT_W != `WDG_BASE_SHIFT + `WDG_PRE_MAX_VALID) begin : g_bad_cnt_w
        $error("counter width must cover the longest timeout");
    end

    // ----------------------------------------
    // crystal tick: three flops, a rising change counts once stages two and three agree
    // ----------------------------------------
    logic [2:0] xs_r;
    logic       xlvl_r;
    wire        xagree = (xs_r[1] == xs_r[2]);
    wire        xtick  = xagree && xs_r[2] && !xlvl_r;

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            xs_r   <= 3'h0;
            xlvl_r <= 1'b0;
        end else begin
            xs_r <= {xs_r[1:0], XTAL_CLK};
            if (xagree) begin
                xlvl_r <= xs_r[2];
            end
        end
    end

    // ----------------------------------------
    // control state
    // ----------------------------------------
    wdg_pre_t           pre_r;
    logic               resp_r;
    logic               en_r;
    logic               stat_r;
    wdg_unlock_t        unl_r;
    wdg_unlock_t        unl_nxt;
    logic [CNT_W-1:0]   cnt_r;

    // lock bit active low: zero pins response to 0 and enable to 1
    wire lock_on   = !LOCK_BYTE[`WDG_LOCK_BIT];
    wire resp_eff  = resp_r && !lock_on;
    wire en_eff    = en_r || lock_on;

    wire ctrl_wr   = SFR_WR && (SFR_ADDR == `WDG_CTRL_ADDR);
    // a write with the unlock bit set arms the sequence, whatever its other bits; the following instruction may write
    wire arm_wr    = ctrl_wr && (unl_r == WDG_UNL_IDLE) && SFR_WDATA[`WDG_UNLOCK_BIT];
    wire apply_wr  = ctrl_wr && (unl_r == WDG_UNL_OPEN);
    wire kick      = apply_wr && SFR_WDATA[`WDG_EN_BIT];

    function automatic logic [CNT_W-1:0] term_mask(input wdg_pre_t code);
        term_mask = CNT_W'((32'h1 << (32'(code) + `WDG_BASE_SHIFT)) - 32'h1);
    endfunction

    wire valid_pre = (pre_r <= `WDG_PRE_MAX_VALID);
    wire timeout   = en_eff && valid_pre && xtick &&
                     ((cnt_r & term_mask(pre_r)) == term_mask(pre_r));
    wire force_sys = (pre_r == `WDG_PRE_AUTO_RST);
    wire force_dl  = (pre_r == `WDG_PRE_DL_RST);
    wire tmo_rst   = timeout && !resp_eff;
    wire tmo_irq   = timeout && resp_eff;
    // any reset the watchdog itself issues puts settings back, but not the status flag
    wire self_rst  = tmo_rst || force_sys || force_dl;

    // ----------------------------------------
    // unlock sequencer
    // ----------------------------------------
    always_comb begin
        unl_nxt = unl_r;
        case (unl_r)
            WDG_UNL_IDLE: begin
                if (arm_wr) begin
                    unl_nxt = INSTR_DONE ? WDG_UNL_OPEN : WDG_UNL_ARMED;
                end
            end
            WDG_UNL_ARMED: begin
                if (INSTR_DONE) begin
                    unl_nxt = WDG_UNL_OPEN;
                end
            end
            WDG_UNL_OPEN: begin
                if (INSTR_DONE || apply_wr) begin
                    unl_nxt = WDG_UNL_IDLE;
                end
            end
            default: begin
                unl_nxt = WDG_UNL_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            unl_r <= WDG_UNL_IDLE;
        end else begin
            unl_r <= self_rst ? WDG_UNL_IDLE : unl_nxt;
        end
    end

    // ----------------------------------------
    // control fields; writes outside the open slot never land
    // ----------------------------------------
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            pre_r  <= `WDG_PRE_RST;
            resp_r <= `WDG_RESP_RST;
            en_r   <= `WDG_EN_RST;
        end else if (self_rst) begin
            pre_r  <= `WDG_PRE_RST;
            resp_r <= `WDG_RESP_RST;
            en_r   <= `WDG_EN_RST;
        end else if (apply_wr) begin
            pre_r <= SFR_WDATA[`WDG_PRE_HI:`WDG_PRE_LO];
            if (!lock_on) begin
                resp_r <= SFR_WDATA[`WDG_RESP_BIT];
                en_r   <= SFR_WDATA[`WDG_EN_BIT];
            end
        end
    end

    // status: set wins over a clearing write; only the pin reset clears it otherwise
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            stat_r <= 1'b0;
        end else if (timeout) begin
            stat_r <= 1'b1;
        end else if (apply_wr && !SFR_WDATA[`WDG_STAT_BIT]) begin
            stat_r <= 1'b0;
        end
    end

    // counter restarts on each kick and after each timeout
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            cnt_r <= '0;
        end else if (kick || timeout || self_rst || !en_eff) begin
            cnt_r <= '0;
        end else if (xtick) begin
            cnt_r <= cnt_r + CNT_W'(1);
        end
    end

    // ----------------------------------------
    // responses; the interrupt has no mask input, only the response bit, pinned to 0 by the lock, holds it off
    // ----------------------------------------
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            SYS_RESET <= 1'b0;
            DL_RESET  <= 1'b0;
            WDT_IRQ   <= 1'b0;
        end else begin
            SYS_RESET <= tmo_rst || force_sys;
            DL_RESET  <= force_dl;
            WDT_IRQ   <= tmo_irq;
        end
    end

    // ----------------------------------------
    // read-back
    // ----------------------------------------
    wire [7:0] ctrl_view = {pre_r, resp_eff, stat_r, en_eff, (unl_r != WDG_UNL_IDLE)};

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            SFR_RDATA <= 8'h00;
        end else begin
            SFR_RDATA <= (SFR_ADDR == `WDG_CTRL_ADDR) ? ctrl_view : 8'h00;
        end
    end

    // ----------------------------------------
    // flash key check and protection write walk
    // ----------------------------------------
    // the lock bit doubles as key msb, so a locked part's blank key is 0x7f
    wire [7:0]  stored_key = {LOCK_BYTE[`WDG_LOCK_BIT], LOCK_BYTE[6:0]};
    wire        key_ok     = (stored_key == FLASH_GUARD_KEY);
    logic       walk_r;

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            walk_r       <= 1'b0;
            PROT_WR      <= 1'b0;
            PROT_WR_ADDR <= `WDG_PROT_TOP_ADDR;
            PROT_DENY    <= 1'b0;
        end else begin
            PROT_DENY <= PROT_REQ && !walk_r && !key_ok;
            if (!walk_r) begin
                PROT_WR      <= 1'b0;
                PROT_WR_ADDR <= `WDG_PROT_TOP_ADDR;
                if (PROT_REQ && key_ok) begin
                    walk_r  <= 1'b1;
                    PROT_WR <= 1'b1;
                end
            end else if (PROT_WR_ADDR == `WDG_PROT_BOT_ADDR) begin
                walk_r       <= 1'b0;
                PROT_WR      <= 1'b0;
                PROT_WR_ADDR <= `WDG_PROT_TOP_ADDR;
            end else begin
                PROT_WR_ADDR <= PROT_WR_ADDR - 14'h1;
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_FORCE_SYS: assert property (@(posedge REF_CLK) disable iff (RST)
        (pre_r == 4'h8) |=> SYS_RESET) else $error("code 8 gave no reset");
    AST_FORCE_DL: assert property (@(posedge REF_CLK) disable iff (RST)
        (pre_r == 4'h9) |=> DL_RESET && !SYS_RESET) else $error("code 9 gave no download reset");
    AST_TMO_RST: assert property (@(posedge REF_CLK) disable iff (RST)
        (timeout && !resp_eff) |=> SYS_RESET && !WDT_IRQ) else $error("timeout without reset");
    AST_TMO_IRQ: assert property (@(posedge REF_CLK) disable iff (RST)
        (timeout && resp_eff) |=> WDT_IRQ && !SYS_RESET) else $error("timeout without interrupt");
    AST_STAT_SET: assert property (@(posedge REF_CLK) disable iff (RST)
        WDT_IRQ || (SYS_RESET && !$past(force_sys)) |-> SFR_RDATA[2] || $past(SFR_ADDR) != 8'hc0 || stat_r)
        else $error("status flag not set after timeout");
    AST_STAT_HOLD: assert property (@(posedge REF_CLK) disable iff (RST)
        stat_r && !(apply_wr && !SFR_WDATA[2]) |=> stat_r) else $error("status flag lost");
    AST_LOCK: assert property (@(posedge REF_CLK) disable iff (RST)
        !$past(RST) && $past(lock_on) && ($past(SFR_ADDR) == `WDG_CTRL_ADDR) |->
        SFR_RDATA[`WDG_EN_BIT] && !SFR_RDATA[`WDG_RESP_BIT]) else $error("lock not forcing settings");
    AST_GUARD: assert property (@(posedge REF_CLK) disable iff (RST)
        ctrl_wr && (unl_r == WDG_UNL_IDLE) && !self_rst |=> $stable(pre_r)) else $error("unguarded write landed");
    AST_KICK: assert property (@(posedge REF_CLK) disable iff (RST)
        kick |=> cnt_r == '0) else $error("kick did not clear counter");
    AST_WALK: assert property (@(posedge REF_CLK) disable iff (RST)
        PROT_REQ && !walk_r && key_ok |=> PROT_WR [*5] ##1 !PROT_WR) else $error("protection walk length wrong");

endmodule // wdg_top

// [src/wdg_regs.svh]
// register offsets, field positions, reset values and timing counts of the watchdog
// assumes inclusion by the watchdog package and top module only
`ifndef WDG_REGS_SVH
`define WDG_REGS_SVH

// ----------------------------------------
// offsets
// ----------------------------------------
`define WDG_CTRL_ADDR       8'hc0
`define WDG_LOCK_BYTE_ADDR  16'hf7ff
`define WDG_PROT_TOP_ADDR   14'h3fff
`define WDG_PROT_BOT_ADDR   14'h3ffb

// ----------------------------------------
// fields of watchdog_control, and the lock bit of the lock byte
// ----------------------------------------
`define WDG_PRE_HI          7
`define WDG_PRE_LO          4
`define WDG_RESP_BIT        3
`define WDG_STAT_BIT        2
`define WDG_EN_BIT          1
`define WDG_UNLOCK_BIT      0
`define WDG_LOCK_BIT        7

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define WDG_PRE_RST         4'h7
`define WDG_RESP_RST        1'b0
`define WDG_EN_RST          1'b1
`define WDG_PRE_AUTO_RST    4'h8
`define WDG_PRE_DL_RST      4'h9
`define WDG_PRE_MAX_VALID   4'h7
`define WDG_BASE_SHIFT      9
`define WDG_CNT_W           16

`endif

// [src/wdg_pkg.sv]
// types shared by the watchdog design
// assumes the register header sits beside it
package wdg_pkg;
    `include "wdg_regs.svh"

    typedef enum logic [1:0] {
        WDG_UNL_IDLE,
        WDG_UNL_ARMED,
        WDG_UNL_OPEN
    } wdg_unlock_t;

    typedef logic [3:0] wdg_pre_t;
endpackage

// [tb/wdg_top_tb_top.sv]
// self-checking bench for the guarded-write watchdog top
// assumes the design sources under src/ and a crystal sped up to one tick per 8 system clocks
`timescale 1ns/10ps
module wdg_top_tb_top;
    import wdg_pkg::*;

    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic        REF_CLK         = 1'b0;
    logic        RST             = 1'b1;
    logic        XTAL_CLK        = 1'b0;
    logic        INSTR_DONE      = 1'b0;
    logic [7:0]  SFR_ADDR        = 8'hc0;
    logic        SFR_WR          = 1'b0;
    logic [7:0]  SFR_WDATA       = 8'h00;
    logic [7:0]  LOCK_BYTE       = 8'hff;
    logic [7:0]  FLASH_GUARD_KEY = 8'hff;
    logic        PROT_REQ        = 1'b0;
    logic [7:0]  SFR_RDATA;
    logic        SYS_RESET;
    logic        DL_RESET;
    logic        WDT_IRQ;
    logic        PROT_WR;
    logic [13:0] PROT_WR_ADDR;
    logic        PROT_DENY;
    int          error_cnt       = 0;
    int          n_checks        = 0;
    int          xtal_div        = 0;
    int          n;

    wdg_top #(.CNT_W(16)) wdg_top_inst (
        .REF_CLK(REF_CLK), .RST(RST), .XTAL_CLK(XTAL_CLK), .INSTR_DONE(INSTR_DONE),
        .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA), .LOCK_BYTE(LOCK_BYTE),
        .FLASH_GUARD_KEY(FLASH_GUARD_KEY), .PROT_REQ(PROT_REQ), .SFR_RDATA(SFR_RDATA),
        .SYS_RESET(SYS_RESET), .DL_RESET(DL_RESET), .WDT_IRQ(WDT_IRQ), .PROT_WR(PROT_WR),
        .PROT_WR_ADDR(PROT_WR_ADDR), .PROT_DENY(PROT_DENY)
    );

    // ----------------------------------------
    // clocks
    // ----------------------------------------
    always #5 REF_CLK = ~REF_CLK;

    // crystal far faster than real so a 512-tick timeout fits the run
    always @(negedge REF_CLK) begin
        xtal_div = (xtal_div == 3) ? 0 : xtal_div + 1;
        if (xtal_div == 0) begin
            XTAL_CLK = ~XTAL_CLK;
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic cyc(input int k);
        repeat (k) @(negedge REF_CLK);
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd(input string what, input logic [7:0] exp);
        cyc(2);
        chk(what, {8'h00, exp}, {8'h00, SFR_RDATA});
    endtask

    // one write instruction; the address stays on the control register throughout
    task automatic wr_ctl(input logic [7:0] d);
        @(negedge REF_CLK);
        SFR_WR = 1'b1;
        SFR_WDATA = d;
        @(negedge REF_CLK);
        SFR_WR = 1'b0;
        INSTR_DONE = 1'b1;
        @(negedge REF_CLK);
        INSTR_DONE = 1'b0;
    endtask

    // codes 10 to 15 are never passed here, they select no timeout
    task automatic guarded(input logic [7:0] d);
        wr_ctl(8'h01);
        wr_ctl(d);
    endtask

    function automatic logic pick(input int s);
        return (s == 0) ? SYS_RESET : (s == 1) ? DL_RESET : WDT_IRQ;
    endfunction

    task automatic wait_sig(input int s, input int maxc, output int cnt);
        cnt = 0;
        while (pick(s) !== 1'b1 && cnt < maxc) begin
            @(negedge REF_CLK);
            cnt++;
        end
    endtask

    task automatic prot(input logic [7:0] key, input logic grant);
        int i;
        @(negedge REF_CLK);
        FLASH_GUARD_KEY = key;
        PROT_REQ = 1'b1;
        @(negedge REF_CLK);
        // walk and deny both start at the edge that takes the request
        PROT_REQ = 1'b0;
        if (grant) begin
            for (i = 0; i < 5; i++) begin
                chk("prot write strobe", 16'h0001, {15'h0, PROT_WR});
                chk("prot write address", 16'h3fff - 16'(i), {2'b00, PROT_WR_ADDR});
                @(negedge REF_CLK);
            end
        end else begin
            chk("prot deny pulse", 16'h0001, {15'h0, PROT_DENY});
        end
        chk("prot write idle", 16'h0000, {15'h0, PROT_WR});
        cyc(2);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_guard;
        rd("ctrl after reset", 8'h72);
        wr_ctl(8'h70);
        rd("write without unlock", 8'h72);
        wr_ctl(8'h01);
        @(negedge REF_CLK);
        INSTR_DONE = 1'b1;
        @(negedge REF_CLK);
        INSTR_DONE = 1'b0;
        wr_ctl(8'h70);
        rd("write one instruction late", 8'h72);
        guarded(8'h50);
        rd("guarded write", 8'h50);
        guarded(8'h72);
        $display("test guard done");
    endtask

    task automatic test_timer;
        guarded(8'h0a);
        wait_sig(2, 5000, n);
        chk("irq after 512 ticks", 16'h0001, {15'h0, n >= 4000 && n <= 4200});
        chk("no reset on irq", 16'h0000, {15'h0, SYS_RESET});
        rd("status after irq", 8'h0e);
        guarded(8'h02);
        rd("status cleared by write", 8'h02);
        wait_sig(0, 5000, n);
        chk("reset after 512 ticks", 16'h0001, {15'h0, n >= 4000 && n <= 4200});
        chk("no irq on reset", 16'h0000, {15'h0, WDT_IRQ});
        rd("status kept by wdt reset", 8'h76);
        @(negedge REF_CLK);
        RST = 1'b1;
        cyc(2);
        RST = 1'b0;
        rd("status cleared by pin", 8'h72);
        guarded(8'h00);
        wait_sig(0, 5000, n);
        chk("disabled never fires", 16'd5000, 16'(n));
        guarded(8'h72);
        $display("test timer done");
    endtask

    task automatic test_codes;
        guarded(8'h82);
        wait_sig(0, 10, n);
        chk("code 8 immediate reset", 16'h0001, {15'h0, n < 10});
        rd("ctrl after code 8", 8'h72);
        guarded(8'h92);
        wait_sig(1, 10, n);
        chk("code 9 download reset", 16'h0001, {15'h0, n < 10});
        rd("ctrl after code 9", 8'h72);
        $display("test codes done");
    endtask

    task automatic test_lock;
        LOCK_BYTE = 8'h7f;
        guarded(8'h38);
        rd("locked response and enable", 8'h32);
        prot(8'h7f, 1'b1);
        prot(8'hff, 1'b0);
        LOCK_BYTE = 8'hff;
        prot(8'h7f, 1'b0);
        prot(8'hff, 1'b1);
        guarded(8'h72);
        $display("test lock done");
    endtask

    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        cyc(5);
        RST = 1'b0;
        test_guard();
        test_timer();
        test_codes();
        test_lock();
        print_verdict();
    end

    // the tests need about 140 us; a hang is cut off well beyond that
    initial begin
        #400000;
        error_cnt++;
        print_verdict();
    end
endmodule // wdg_top_tb_top
